/* File: shared/scs_pkg.sv */
// Package: register map, field layout and types of the SYSREF capture block
package scs_pkg;
  localparam int         ADDR_W      = 12;      // APB byte address width
  localparam int         DATA_W      = 32;      // APB data width
  localparam int         BYTE_W      = 8;       // Register width
  localparam int         NIB_W       = 4;       // Nibble fields
  localparam int         TS_W        = 7;       // Timestamp delay field width
  localparam int         SAMPLE_W    = 14;      // Converter sample width
  localparam int         TS_DEPTH    = 128;     // Delay line length, cycles
  localparam int         IDX_W       = 10;      // Register index width
  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_CTRL    = 10'h120; // SYSREF control
  localparam logic [9:0] IDX_NSHOT   = 10'h121; // N-shot ignore count
  localparam logic [9:0] IDX_SKEW    = 10'h122; // sysref_skew_windows
  localparam logic [9:0] IDX_TSDLY   = 10'h123; // sysref_timestamp_delay
  localparam logic [9:0] IDX_SHSTAT  = 10'h128; // sysref_setup_hold_status
  localparam logic [9:0] IDX_PHSTAT  = 10'h129; // sysref_divider_phase_status
  localparam logic [9:0] IDX_EVCNT   = 10'h12a; // sysref_event_count
  localparam logic [9:0] IDX_SYNC    = 10'h1ff; // sync_mode_select
  localparam logic [1:0] LOW_ZERO    = 2'h0;    // Word alignment bits
  // Control register fields
  localparam int         FLAGRST_BIT = 6;
  localparam int         TRANS_BIT   = 4;
  localparam int         EDGE_BIT    = 3;
  localparam int         MODE_LSB    = 1;
  localparam int         NEG_LSB     = 2;
  localparam int         POS_LSB     = 0;
  localparam logic [7:0] CTRL_WMASK  = 8'h5e;   // Writable control bits
  localparam logic [7:0] RST_BYTE    = 8'h00;   // Reset value of registers
  // Divider phase in half input clock cycles
  localparam logic [3:0] PHASE_ZERO  = 4'h0;
  localparam logic [3:0] PHASE_STEP  = 4'h2;
  localparam logic [7:0] CNT_ONE     = 8'h01;
  localparam logic [3:0] NIB_ONE     = 4'h1;
  localparam logic [6:0] DLY_NONE    = 7'h00;
  localparam logic [6:0] DLY_ONE     = 7'h01;
  typedef enum logic [1:0] {
    MODE_OFF   = 2'b00,
    MODE_CONT  = 2'b01,
    MODE_NSHOT = 2'b10
  } scs_mode_type;
  typedef enum logic [0:0] {
    NS_ARMED = 1'b0,
    NS_SPENT = 1'b1
  } scs_nshot_type;
  typedef struct packed {
    logic                tag;   // SYSREF timestamp control bit
    logic [SAMPLE_W-1:0] data;  // Converter sample
  } scs_word_type;
endpackage

/* File: verilog/scs_sysref_capture.sv */
// SYSREF pin synchroniser with clock edge and transition selection
`timescale 1ns/1ps
module scs_sysref_capture (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic clk_en,
  input  wire logic sysref_in,
  input  wire logic edge_fall,
  input  wire logic trans_fall,
  output logic      evt
);
  import scs_pkg::*;

  logic rise1;  // First stage, rising edge
  logic rise2;  // Second stage, rising edge
  logic fall1;  // First stage, falling edge
  logic fall2;  // Second stage, back on rising edge
  logic sel_d;  // Previous selected level
  logic sel;    // Level from the chosen edge

  // Rising edge sampler
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rise1 <= 1'b0;
      rise2 <= 1'b0;
    end else if (clk_en) begin
      rise1 <= sysref_in;
      rise2 <= rise1;
    end
  end

  // Falling edge sampler, first stage only
  always_ff @(negedge clk) begin
    if (!rst_n) begin
      fall1 <= 1'b0;
    end else if (clk_en) begin
      fall1 <= sysref_in;
    end
  end

  // Edge select picks one synchronised level
  assign sel = edge_fall ? fall2 : rise2;

  // Second falling stage and transition detector
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fall2 <= 1'b0;
      sel_d <= 1'b0;
      evt   <= 1'b0;
    end else if (clk_en) begin
      fall2 <= fall1;
      sel_d <= sel;
      evt   <= trans_fall ? (sel_d & ~sel) : (~sel_d & sel);
    end
  end
endmodule

/* File: verilog/scs_ts_delay.sv */
// Programmable delay line for the SYSREF timestamp mark
`timescale 1ns/1ps
module scs_ts_delay #(
  parameter int DEPTH = scs_pkg::TS_DEPTH
) (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     clk_en,
  input  wire logic [$clog2(DEPTH)-1:0] delay,
  input  wire logic                     mark_in,
  output logic                          mark_out
);
  import scs_pkg::*;

  logic [DEPTH-2:0] pipe;  // Mark history, one cycle per bit

  // Shift the mark along each sample clock
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pipe <= '0;
    end else if (clk_en) begin
      pipe <= {pipe[DEPTH-3:0], mark_in};
    end
  end

  // Tap at the programmed cycle count
  always_comb begin
    if (delay == DLY_NONE) begin
      mark_out = mark_in;
    end else begin
      mark_out = pipe[delay - DLY_ONE];
    end
  end
endmodule

/* File: verilog/scs_sysref_sync.sv */
// SYSREF capture and synchronisation control with APB registers
`timescale 1ns/1ps
module scs_sysref_sync (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     clk_en,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [scs_pkg::ADDR_W-1:0] paddr,
  input  wire logic [scs_pkg::DATA_W-1:0] pwdata,
  output logic [scs_pkg::DATA_W-1:0]    prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     sysref_in,
  input  wire logic [scs_pkg::SAMPLE_W-1:0] sample_in,
  input  wire logic                     sample_valid,
  output scs_pkg::scs_word_type         out_word,
  output logic                          out_valid,
  output logic                          div_reset,
  output logic                          link_drop
);
  import scs_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Helper functions

  // Address matches a register index
  function automatic logic reg_sel(input logic [ADDR_W-1:0] a,
                                   input logic [IDX_W-1:0]  idx);
    reg_sel = (a == {idx, LOW_ZERO});
  endfunction

  // Cycles the capture lags the divider
  function automatic logic [2:0] late_of(input logic [3:0] ph);
    late_of = ph[3:1];
  endfunction

  // Cycles the capture leads the divider
  function automatic logic [2:0] early_of(input logic [3:0] ph);
    early_of = 3'((PHASE_ZERO - ph) >> 1);
  endfunction

  // Capture lies inside the skew tolerance
  function automatic logic in_window(input logic [3:0] ph,
                                     input logic [1:0] neg,
                                     input logic [1:0] pos);
    if (ph[3]) begin
      in_window = (early_of(ph) <= {1'b0, neg});
    end else begin
      in_window = (late_of(ph) <= {1'b0, pos});
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [BYTE_W-1:0] ctrl;        // Flag reset, edge, transition, mode
  logic [NIB_W-1:0]  nshot_cnt;   // Transitions to ignore in N-shot
  logic [NIB_W-1:0]  skew;        // Negative and positive windows
  logic [TS_W-1:0]   tsdly;       // Timestamp delay in cycles
  logic              sync_mode;   // 0 divider sync, 1 timestamp
  logic [NIB_W-1:0]  setup_stat;  // Lead of last capture
  logic [NIB_W-1:0]  hold_stat;   // Lag of last capture
  logic [NIB_W-1:0]  phase_stat;  // Divider phase at last capture
  logic [BYTE_W-1:0] ev_cnt;      // Captured event count
  logic [3:0]        div_cnt;     // Internal divider phase
  scs_nshot_type     ns_state;    // N-shot progress
  logic [NIB_W-1:0]  ign_cnt;     // Transitions ignored so far
  scs_mode_type      mode;        // Decoded mode field
  logic              flag_rst;    // Flags held in reset
  logic              cap_evt;     // Transition from the pin
  logic              captured;    // Transition while enabled
  logic              act;         // Transition acted upon
  logic              hit;         // Capture inside skew window
  logic              realign;     // Capture outside the window
  logic [3:0]        cap_phase;   // Phase seen by this capture
  logic              ts_mark;     // Timestamp event
  logic              tag_now;     // Delayed timestamp mark
  logic              setup_ph;    // APB setup phase
  logic              wr_en;       // APB write completes
  logic              rearm;       // Restart N-shot counting
  logic              mapped;      // Address decodes
  logic [BYTE_W-1:0] rd_byte;     // Read data of addressed register

  ////////////////////////////////////////////////////////////////////////
  // Field decode

  assign mode      = scs_mode_type'(ctrl[MODE_LSB +: 2]);
  assign flag_rst  = ctrl[FLAGRST_BIT];
  assign setup_ph  = psel & ~penable;
  assign wr_en     = psel & penable & pready & pwrite;
  assign cap_phase = 4'(div_cnt + {3'b000, ctrl[EDGE_BIT]});
  assign hit       = in_window(cap_phase, skew[NEG_LSB +: 2], skew[POS_LSB +: 2]);
  assign realign   = act & ~hit;
  assign captured  = cap_evt & (mode != MODE_OFF);
  assign ts_mark   = act & sync_mode;
  assign rearm     = (wr_en & (reg_sel(paddr, IDX_CTRL) | reg_sel(paddr, IDX_NSHOT)))
                   | (mode != MODE_NSHOT);

  ////////////////////////////////////////////////////////////////////////
  // SYSREF front end and timestamp delay

  scs_sysref_capture u_capture (
    .clk        (clk),
    .rst_n      (rst_n),
    .clk_en     (clk_en),
    .sysref_in  (sysref_in),
    .edge_fall  (ctrl[EDGE_BIT]),
    .trans_fall (ctrl[TRANS_BIT]),
    .evt        (cap_evt)
  );

  scs_ts_delay #(
    .DEPTH (TS_DEPTH)
  ) u_delay (
    .clk      (clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .delay    (tsdly),
    .mark_in  (ts_mark),
    .mark_out (tag_now)
  );

  ////////////////////////////////////////////////////////////////////////
  // APB slave

  // Read mux, address decode
  always_comb begin
    mapped  = 1'b1;
    rd_byte = RST_BYTE;
    if (reg_sel(paddr, IDX_CTRL)) begin
      rd_byte = ctrl;
    end else if (reg_sel(paddr, IDX_NSHOT)) begin
      rd_byte = {{NIB_W{1'b0}}, nshot_cnt};
    end else if (reg_sel(paddr, IDX_SKEW)) begin
      rd_byte = {{NIB_W{1'b0}}, skew};
    end else if (reg_sel(paddr, IDX_TSDLY)) begin
      rd_byte = {1'b0, tsdly};
    end else if (reg_sel(paddr, IDX_SHSTAT)) begin
      rd_byte = {hold_stat, setup_stat};
    end else if (reg_sel(paddr, IDX_PHSTAT)) begin
      rd_byte = {{NIB_W{1'b0}}, phase_stat};
    end else if (reg_sel(paddr, IDX_EVCNT)) begin
      rd_byte = ev_cnt;
    end else if (reg_sel(paddr, IDX_SYNC)) begin
      rd_byte = {{(BYTE_W-1){1'b0}}, sync_mode};
    end else begin
      mapped  = 1'b0;  // Unmapped reads zero
    end
  end

  // One wait state, data latched in setup
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= psel & penable & ~pready;
      if (setup_ph) begin
        prdata  <= {{(DATA_W-BYTE_W){1'b0}}, rd_byte};
        pslverr <= ~mapped;
      end
    end
  end

  // Writable configuration registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl      <= RST_BYTE;
      nshot_cnt <= RST_BYTE[NIB_W-1:0];
      skew      <= RST_BYTE[NIB_W-1:0];
      tsdly     <= RST_BYTE[TS_W-1:0];
      sync_mode <= 1'b0;
    end else if (clk_en && wr_en) begin
      if (reg_sel(paddr, IDX_CTRL)) begin
        ctrl <= pwdata[BYTE_W-1:0] & CTRL_WMASK;
      end else if (reg_sel(paddr, IDX_NSHOT)) begin
        nshot_cnt <= pwdata[NIB_W-1:0];
      end else if (reg_sel(paddr, IDX_SKEW)) begin
        skew <= pwdata[NIB_W-1:0];
      end else if (reg_sel(paddr, IDX_TSDLY)) begin
        tsdly <= pwdata[TS_W-1:0];
      end else if (reg_sel(paddr, IDX_SYNC)) begin
        sync_mode <= pwdata[0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode handling and N-shot counting

  // Which captures are acted upon
  always_comb begin
    case (mode)
      MODE_CONT:  act = captured;
      MODE_NSHOT: act = captured & (ns_state == NS_ARMED)
                      & (ign_cnt == nshot_cnt);
      default:    act = 1'b0;
    endcase
  end

  // N-shot state machine
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ns_state <= NS_ARMED;
      ign_cnt  <= RST_BYTE[NIB_W-1:0];
    end else if (clk_en) begin
      if (rearm) begin
        ns_state <= NS_ARMED;
        ign_cnt  <= RST_BYTE[NIB_W-1:0];
      end else begin
        case (ns_state)
          NS_ARMED: begin
            if (captured && ign_cnt == nshot_cnt) begin
              ns_state <= NS_SPENT;
            end else if (captured) begin
              ign_cnt <= ign_cnt + NIB_ONE;
            end
          end
          NS_SPENT: begin
            ns_state <= NS_SPENT;  // Wait for rearm
          end
          default: begin
            ns_state <= NS_ARMED;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status flags and event counter

  // Setup, hold and phase status
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      setup_stat <= RST_BYTE[NIB_W-1:0];
      hold_stat  <= RST_BYTE[NIB_W-1:0];
      phase_stat <= RST_BYTE[NIB_W-1:0];
    end else if (clk_en) begin
      if (act) begin
        phase_stat <= cap_phase;
      end
      if (flag_rst) begin
        setup_stat <= RST_BYTE[NIB_W-1:0];
        hold_stat  <= RST_BYTE[NIB_W-1:0];
      end else if (act && cap_phase[3]) begin
        setup_stat <= {1'b0, early_of(cap_phase)};
        hold_stat  <= RST_BYTE[NIB_W-1:0];
      end else if (act) begin
        setup_stat <= RST_BYTE[NIB_W-1:0];
        hold_stat  <= {1'b0, late_of(cap_phase)};
      end
    end
  end

  // Wrapping count of captured events
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ev_cnt <= RST_BYTE;
    end else if (clk_en) begin
      if (flag_rst) begin
        ev_cnt <= RST_BYTE;
      end else if (captured) begin
        ev_cnt <= ev_cnt + CNT_ONE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Divider alignment and link drop

  // Divider runs free unless realigned
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_cnt   <= PHASE_ZERO;
      div_reset <= 1'b0;
      link_drop <= 1'b0;
    end else if (clk_en) begin
      if (realign && !sync_mode) begin
        div_cnt   <= PHASE_ZERO;
        div_reset <= 1'b1;
        link_drop <= 1'b1;
      end else begin
        div_cnt   <= div_cnt + PHASE_STEP;
        div_reset <= 1'b0;
        link_drop <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output word with timestamp bit

  // Tag the sample that meets the delayed mark
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      out_word  <= '0;
      out_valid <= 1'b0;
    end else if (clk_en) begin
      out_valid <= sample_valid;
      if (sample_valid) begin
        out_word.data <= sample_in;
        out_word.tag  <= tag_now;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n || !clk_en);

  sequence jesd_evt;
    act && !hit && !sync_mode;
  endsequence

  sequence ts_evt;
    act && sync_mode && tsdly == DLY_NONE && sample_valid;
  endsequence

  a_jesd_realign: assert property (jesd_evt |=> (div_reset && link_drop &&
      div_cnt == PHASE_ZERO) ##1 div_cnt == PHASE_STEP)
    else $error("divider not realigned by SYSREF");
  a_link_drop: assert property (link_drop |-> div_reset)
    else $error("link drop without divider reset");
  a_ts_divfree: assert property ((act && sync_mode) |=> !div_reset && !link_drop &&
      div_cnt == 4'($past(div_cnt) + PHASE_STEP))
    else $error("timestamp event touched divider or link");
  a_window_ignore: assert property ((act && hit) |=> !div_reset && !link_drop)
    else $error("in-window capture acted upon");
  a_phase_record: assert property (act |=> phase_stat == $past(cap_phase))
    else $error("divider phase not recorded");
  a_count_step: assert property ((captured && !flag_rst) |=>
      ev_cnt == 8'($past(ev_cnt) + CNT_ONE))
    else $error("event counter did not step");
  a_count_wrap: assert property ((captured && !flag_rst && ev_cnt == 8'hff) |=>
      ev_cnt == RST_BYTE)
    else $error("event counter did not wrap");
  a_flag_clear: assert property (flag_rst |=> setup_stat == RST_BYTE[NIB_W-1:0] &&
      hold_stat == RST_BYTE[NIB_W-1:0] && ev_cnt == RST_BYTE)
    else $error("flags not held clear");
  a_ts_tag: assert property (ts_evt |=> out_valid && out_word.tag)
    else $error("timestamp tag missing from output word");
  a_nshot_skip: assert property ((mode == MODE_NSHOT && ign_cnt != nshot_cnt) |-> !act)
    else $error("N-shot acted before ignore count");
  a_mode_off: assert property ((mode == MODE_OFF) |=> $stable(ev_cnt) ||
      ev_cnt == RST_BYTE)
    else $error("capture counted while disabled");
endmodule

/* File: testbench/scs_sysref_source.sv */
// Model of the external clock source that drives the SYSREF pin
`timescale 1ns/1ps
module scs_sysref_source #(
  parameter int HIGH_CYC = 2  // Pulse width in sample clocks
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic fire,
  output logic      sysref_out
);
  int left;  // High cycles still to send
  ////////////////////////////////////////
  // One pulse per request, changed just after the edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      left       <= 0;
      sysref_out <= 1'b0;
    end else if (fire) begin
      left       <= HIGH_CYC - 1;
      sysref_out <= 1'b1;
    end else if (left > 0) begin
      left <= left - 1;
    end else begin
      sysref_out <= 1'b0;
    end
  end
endmodule

/* File: testbench/tb_top.sv */
// Self-checking bench of the SYSREF capture and sync block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb_top;
  import scs_pkg::*;
  typedef struct {
    logic wr; logic [9:0] idx; logic [7:0] wdat; logic [7:0] exp; logic err;
  } scs_row_type;
  typedef struct {
    logic [3:0] skew; int gap; int act; logic [3:0] ph;
  } scs_skew_type;
  localparam int LIMIT = 12000;  // Cycle ceiling of the run
  logic              clk, rst_n, psel, penable, pwrite, fire, sysref;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  logic              pready, pslverr, err, sample_valid, out_valid;
  logic              div_reset, link_drop;
  logic [SAMPLE_W-1:0] sample_in, tdat, k0, off;
  scs_word_type      out_word;
  int                fails, checks, cyc, last, ea, dr, ld, ntag, k, n0;
  // Register rows: write, index, byte written, byte read back, error
  scs_row_type rows[12] = '{
    '{0, IDX_CTRL, 8'h00, 8'h00, 0}, '{1, IDX_CTRL, 8'hff, 8'h5e, 0},
    '{1, IDX_CTRL, 8'h00, 8'h00, 0}, '{1, IDX_NSHOT, 8'hff, 8'h0f, 0},
    '{1, IDX_SKEW, 8'hff, 8'h0f, 0}, '{1, IDX_TSDLY, 8'hff, 8'h7f, 0},
    '{1, IDX_SHSTAT, 8'hff, 8'h00, 0}, '{1, IDX_PHSTAT, 8'hff, 8'h00, 0},
    '{1, IDX_EVCNT, 8'hff, 8'h00, 0}, '{1, IDX_SYNC, 8'hff, 8'h01, 0},
    '{1, IDX_SYNC, 8'h00, 8'h00, 0}, '{1, 10'h001, 8'hff, 8'h00, 1}};
  // Skew rows: window, capture spacing, realign expected, phase
  scs_skew_type sk[10] = '{
    '{4'h0, 17, 0, 4'h0}, '{4'h0, 18, 1, 4'h2}, '{4'h1, 18, 0, 4'h2},
    '{4'h1, 19, 1, 4'h4}, '{4'h2, 20, 1, 4'h6}, '{4'h3, 20, 0, 4'h6},
    '{4'h4, 16, 0, 4'he}, '{4'h0, 16, 1, 4'he}, '{4'hc, 14, 0, 4'ha},
    '{4'h8, 14, 1, 4'ha}};
  logic [6:0] dl[3] = '{7'h00, 7'h05, 7'h7f};  // Timestamp delays
  logic [9:0] ids[6] = '{IDX_CTRL, IDX_NSHOT, IDX_SKEW, IDX_TSDLY, IDX_SYNC, IDX_EVCNT};
  scs_sysref_sync dut (
    .clk(clk), .rst_n(rst_n), .clk_en(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sysref_in(sysref), .sample_in(sample_in),
    .sample_valid(sample_valid), .out_word(out_word), .out_valid(out_valid),
    .div_reset(div_reset), .link_drop(link_drop));
  scs_sysref_source src (.clk(clk), .rst_n(rst_n), .fire(fire), .sysref_out(sysref));
  ////////////////////////////////////////
  // Clock, and sample counter fed as sample data
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc       <= cyc + 1;
    sample_in <= cyc[SAMPLE_W-1:0];
    if (cyc == LIMIT) begin
      fails++;
      final_report();
    end
  end
  ////////////////////////////////////////
  // Verdict and end of run
  task automatic final_report();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // One APB transfer; waits for pready
  task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {idx, LOW_ZERO};
    pwdata  <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [9:0] idx, input logic [7:0] e, input string nm);
    apb(1'b0, idx, 8'h00);
    `CHK(nm, {24'h000000, e}, rd)
  endtask
  // Pin pulse requested at cycle t
  task automatic fire_at(input int t);
    while (cyc < t) @(posedge clk);
    fire <= 1'b1;
    last = cyc;
    @(posedge clk);
    fire <= 1'b0;
  endtask
  // Count realign pulses and tagged words over n cycles
  task automatic watch(input int n);
    dr = 0;
    ld = 0;
    ntag = 0;
    repeat (n) begin
      @(posedge clk);
      dr += int'(div_reset === 1'b1);
      ld += int'(link_drop === 1'b1);
      if (out_valid === 1'b1 && out_word.tag === 1'b1) begin
        ntag++;
        tdat = out_word.data;
      end
    end
  endtask
  // Pulses 11 apart until the divider is realigned; ea marks it
  task automatic align();
    ea = -1;
    for (int i = 0; i < 9 && ea < 0; i++) begin
      fire_at(i == 0 ? cyc : last + 11);
      n0 = i + 1;
      watch(9);
      if (dr > 0) ea = last;
    end
    `CHK("aligned", 1, int'(ea >= 0))
  endtask
  ////////////////////////////////////////
  // Main sequence
  initial begin
    {rst_n, psel, penable, pwrite, fire, sample_valid} = '0;
    {paddr, pwdata} = '0;
    {fails, checks} = '0;
    repeat (8) @(posedge clk);
    rst_n        <= 1'b1;
    sample_valid <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wr) apb(1'b1, rows[i].idx, rows[i].wdat);
      rdchk(rows[i].idx, rows[i].exp, "register");
      `CHK("pslverr", rows[i].err, err)
    end
    // Skew windows in divider sync mode
    apb(1'b1, IDX_CTRL, 8'h02);
    foreach (sk[i]) begin
      apb(1'b1, IDX_SKEW, {4'h0, sk[i].skew});
      align();
      fire_at(ea + sk[i].gap);
      watch(12);
      `CHK("div_reset", sk[i].act, dr)
      `CHK("link_drop", sk[i].act, ld)
      rdchk(IDX_PHSTAT, {4'h0, sk[i].ph}, "phase");
      // Lead cycles in setup nibble, lag cycles in hold nibble
      rdchk(IDX_SHSTAT, sk[i].ph[3] ? {4'h0, 4'(5'h10 - sk[i].ph) >> 1}
                                    : {1'b0, sk[i].ph[3:1], 4'h0}, "setup hold");
    end
    // Falling clock edge: half-cycle phase, inside a zero window
    apb(1'b1, IDX_SKEW, 8'h00);
    align();
    apb(1'b1, IDX_CTRL, 8'h0a);
    fire_at(ea + 18);
    watch(12);
    `CHK("fall edge", 0, dr)
    rdchk(IDX_PHSTAT, 8'h01, "fall phase");
    apb(1'b1, IDX_CTRL, 8'h02);
    // Timestamp mode: one tag, moved by the delay, no realign
    apb(1'b1, IDX_SYNC, 8'h01);
    foreach (dl[i]) begin
      apb(1'b1, IDX_TSDLY, {1'b0, dl[i]});
      fire_at(cyc);
      watch(150);
      `CHK("tags", 1, ntag)
      `CHK("ts realign", 0, dr + ld)
      off = tdat - last[SAMPLE_W-1:0];
      if (i == 0) k0 = off;
      `CHK("tag delay", k0 + SAMPLE_W'(dl[i]), off)
    end
    // High to low transition: tag later by the source pulse width of two
    apb(1'b1, IDX_CTRL, 8'h12);
    apb(1'b1, IDX_TSDLY, 8'h00);
    fire_at(cyc);
    watch(20);
    `CHK("fall tags", 1, ntag)
    off = tdat - last[SAMPLE_W-1:0];
    `CHK("fall trans", k0 + 14'h0002, off)
    // Counter wrap, then flag reset
    apb(1'b1, IDX_CTRL, 8'h42);
    apb(1'b1, IDX_CTRL, 8'h02);
    repeat (258) begin
      fire_at(cyc);
      repeat (3) @(posedge clk);
    end
    repeat (8) @(posedge clk);
    apb(1'b1, IDX_CTRL, 8'h00);
    rdchk(IDX_EVCNT, 8'h02, "count wrap");
    apb(1'b1, IDX_CTRL, 8'h40);
    rdchk(IDX_EVCNT, 8'h00, "count clear");
    rdchk(IDX_SHSTAT, 8'h00, "setup hold");
    // N-shot: two ignored, third acted, then none
    apb(1'b1, IDX_SKEW, 8'h00);
    apb(1'b1, IDX_SYNC, 8'h00);
    apb(1'b1, IDX_CTRL, 8'h02);
    n0 = 0;
    align();
    apb(1'b1, IDX_NSHOT, 8'h02);
    apb(1'b1, IDX_CTRL, 8'h04);
    for (k = 0; k < 4; k++) begin
      fire_at(ea + 34 + 16 * k);
      watch(15);
      `CHK("nshot", int'(k == 2), dr)
    end
    repeat (8) @(posedge clk);
    apb(1'b1, IDX_CTRL, 8'h00);
    // Align pulses plus all four N-shot pulses are counted
    rdchk(IDX_EVCNT, 8'(n0 + 4), "nshot count");
    // Reset in mid-run clears the registers
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    foreach (ids[i]) rdchk(ids[i], 8'h00, "reset");
    final_report();
  end
endmodule
